// [rtl/hcd_cmd_ctrl.sv]
// Host command register, doorbell handshake and status flags on AHB-Lite.
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module hcd_cmd_ctrl
   import hcd_pkg::*;
#(
   parameter bit LR_IMPL = 1'b1 // Light reset option present
) (
   input wire logic sys_clk, // System clock, 20 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Response, always OKAY
   output logic irq, // Level interrupt
   output logic halted // Controller halted flag
);

   typedef struct packed {
      logic run;
      logic halt;
      logic async_en;
      logic [7:0] thresh;
      logic lr_busy;
      logic [4:0] lr_cnt;
      hcd_db_t db_state;
      logic [2:0] ev_cnt;
      logic aa_flag;
      logic aa_en;
      logic irq;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic rdy;
      logic resp;
   } hcd_state_t;

   localparam hcd_state_t ST_RST = '{
      run: 1'b0,
      halt: 1'b1,
      async_en: 1'b0,
      thresh: HCD_THR_RST,
      lr_busy: 1'b0,
      lr_cnt: 5'h00,
      db_state: HCD_DB_IDLE,
      ev_cnt: 3'h0,
      aa_flag: 1'b0,
      aa_en: 1'b0,
      irq: 1'b0,
      wr_pend: 1'b0,
      wr_addr: 12'h000,
      rdata: 32'h0000_0000,
      rdy: 1'b1,
      resp: 1'b0
   };

   hcd_state_t s_q;
   hcd_state_t s_d;
   logic boundary;
   logic access;
   logic [7:0] new_thr;
   logic thr_ok;
   logic [31:0] cmd_view;
   logic [31:0] sts_view;
   logic [31:0] ien_view;

   // Threshold boundary timer
   hcd_thr_timer u_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .run(s_q.run),
      .thresh(s_q.thresh),
      .boundary(boundary)
   );

   // Address phase accepted
   assign access = hsel & hready & htrans[1];
   assign new_thr = hwdata[HCD_CMD_THR_MSB:HCD_CMD_THR_LSB];

   // Only the documented power-of-two codes are accepted
   always_comb begin
      case (new_thr)
         HCD_THR_1, HCD_THR_2, HCD_THR_4, HCD_THR_8, HCD_THR_16: thr_ok = 1'b1;
         HCD_THR_32, HCD_THR_64: thr_ok = 1'b1;
         default: thr_ok = 1'b0;
      endcase
   end

   // Register read views
   always_comb begin
      cmd_view = 32'h0000_0000;
      cmd_view[HCD_CMD_THR_MSB:HCD_CMD_THR_LSB] = s_q.thresh;
      cmd_view[HCD_CMD_LR_BIT] = LR_IMPL & s_q.lr_busy;
      cmd_view[HCD_CMD_DB_BIT] = (s_q.db_state != HCD_DB_IDLE);
      cmd_view[HCD_CMD_ASE_BIT] = s_q.async_en;
      cmd_view[HCD_CMD_RUN_BIT] = s_q.run;
      sts_view = 32'h0000_0000;
      sts_view[HCD_STS_HALT_BIT] = ~s_q.run;
      sts_view[HCD_STS_AA_BIT] = s_q.aa_flag;
      ien_view = 32'h0000_0000;
      ien_view[HCD_IEN_AA_BIT] = s_q.aa_en;
   end

   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.rdy = 1'b1;
      s_d.resp = 1'b0;
      s_d.wr_pend = 1'b0;
      s_d.rdata = 32'h0000_0000;

      // Address phase: latch writes, capture read data
      if (access) begin
         s_d.wr_pend = hwrite;
         s_d.wr_addr = haddr[11:0];
         if (!hwrite) begin
            case (haddr[11:0])
               HCD_CMD_OFS: s_d.rdata = cmd_view;
               HCD_STS_OFS: begin
                  s_d.rdata = sts_view;
                  s_d.aa_flag = 1'b0;
               end
               HCD_IEN_OFS: s_d.rdata = ien_view;
               default: s_d.rdata = 32'h0000_0000;
            endcase
         end
      end

      // Data phase: apply writes, ignored while a light reset runs
      if (s_q.wr_pend && !s_q.lr_busy) begin
         case (s_q.wr_addr)
            HCD_CMD_OFS: begin
               s_d.run = hwdata[HCD_CMD_RUN_BIT];
               s_d.async_en = hwdata[HCD_CMD_ASE_BIT];
               if (thr_ok) begin
                  s_d.thresh = new_thr;
               end
               if (hwdata[HCD_CMD_DB_BIT] && s_q.db_state == HCD_DB_IDLE) begin
                  s_d.db_state = HCD_DB_EVICT;
                  s_d.ev_cnt = 3'h0;
               end
            end
            HCD_IEN_OFS: s_d.aa_en = hwdata[HCD_IEN_AA_BIT];
            default: s_d.aa_en = s_q.aa_en;
         endcase
      end

      // Doorbell sequencer: evict, set flag, then drop the doorbell
      case (s_q.db_state)
         HCD_DB_IDLE: s_d.ev_cnt = 3'h0;
         HCD_DB_EVICT: begin
            if (s_q.ev_cnt == HCD_EVICT_LAST) begin
               s_d.aa_flag = 1'b1;
               s_d.db_state = HCD_DB_DONE;
            end else begin
               s_d.ev_cnt = 3'(s_q.ev_cnt + 3'h1);
            end
         end
         HCD_DB_DONE: s_d.db_state = HCD_DB_IDLE;
         default: s_d.db_state = HCD_DB_IDLE;
      endcase

      // Interrupt: raised at a boundary, or at once while halted
      if (!(s_q.aa_flag && s_q.aa_en)) begin
         s_d.irq = 1'b0;
      end else if (boundary || !s_q.run) begin
         s_d.irq = 1'b1;
      end

      // Light reset: run the countdown, then release
      if (s_q.lr_busy) begin
         if (s_q.lr_cnt == HCD_LRST_LAST) begin
            s_d.lr_busy = 1'b0;
         end else begin
            s_d.lr_cnt = 5'(s_q.lr_cnt + 5'h01);
         end
      end

      // Light reset start reinitialises controller state only
      if (LR_IMPL && s_q.wr_pend && !s_q.lr_busy && s_q.wr_addr == HCD_CMD_OFS
          && hwdata[HCD_CMD_LR_BIT]) begin
         s_d.run = 1'b0;
         s_d.async_en = 1'b0;
         s_d.thresh = HCD_THR_RST;
         s_d.db_state = HCD_DB_IDLE;
         s_d.ev_cnt = 3'h0;
         s_d.aa_flag = 1'b0;
         s_d.aa_en = 1'b0;
         s_d.irq = 1'b0;
         s_d.lr_busy = 1'b1;
         s_d.lr_cnt = 5'h00;
      end

      // Halted flag kept in its own flop so the pin has no gate
      s_d.halt = ~s_d.run;
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from state
   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.rdy;
   assign hresp = s_q.resp;
   assign irq = s_q.irq;
   assign halted = s_q.halt;

endmodule
`default_nettype wire

// [rtl/hcd_pkg.sv]
// Constants and types for the host command, doorbell and status block.
// What this block does
// - The threshold field also accepts 0x20 and 0x40, giving one interrupt per 32 or 64 microframes.
// - Threshold codes 0x01 to 0x10 give 1, 2, 4, 8 and 16 microframes between interrupts.
// - Without the light reset option, the light reset bit always reads zero.
// - A light reset reinitialises controller state and leaves port state and companion routing alone.
// - The light reset bit reads one while the reset runs and zero once it has finished.
// - Once cached schedule state is evicted after the doorbell, status bit 5 is set.
// - With interrupt enable bit 5 set, the flag raises an interrupt at the next threshold boundary while running, or at once while halted.
// - The controller clears the doorbell itself, only after it has set the status flag.
package hcd_pkg;

   // Register byte offsets
   localparam logic [11:0] HCD_CMD_OFS = 12'h000;
   localparam logic [11:0] HCD_STS_OFS = 12'h004;
   localparam logic [11:0] HCD_IEN_OFS = 12'h008;

   // Command register fields
   localparam int HCD_CMD_RUN_BIT = 0;
   localparam int HCD_CMD_ASE_BIT = 5;
   localparam int HCD_CMD_DB_BIT = 6;
   localparam int HCD_CMD_LR_BIT = 7;
   localparam int HCD_CMD_THR_LSB = 16;
   localparam int HCD_CMD_THR_MSB = 23;

   // Status and interrupt enable fields
   localparam int HCD_STS_AA_BIT = 5;
   localparam int HCD_STS_HALT_BIT = 12;
   localparam int HCD_IEN_AA_BIT = 5;

   // Threshold codes in microframes
   localparam logic [7:0] HCD_THR_1 = 8'h01;
   localparam logic [7:0] HCD_THR_2 = 8'h02;
   localparam logic [7:0] HCD_THR_4 = 8'h04;
   localparam logic [7:0] HCD_THR_8 = 8'h08;
   localparam logic [7:0] HCD_THR_16 = 8'h10;
   localparam logic [7:0] HCD_THR_32 = 8'h20;
   localparam logic [7:0] HCD_THR_64 = 8'h40;
   localparam logic [7:0] HCD_THR_RST = 8'h08;

   // Timing
   localparam int HCD_CLK_PERIOD_NS = 50;
   localparam int HCD_MFRAME_NS = 125000;
   localparam int HCD_MFRAME_CYC = HCD_MFRAME_NS / HCD_CLK_PERIOD_NS;
   localparam logic [11:0] HCD_MFRAME_LAST = 12'(HCD_MFRAME_CYC - 1);
   localparam logic [4:0] HCD_LRST_LAST = 5'h0f;
   localparam logic [2:0] HCD_EVICT_LAST = 3'h3;

   // Doorbell sequencer states
   typedef enum logic [2:0] {
      HCD_DB_IDLE = 3'b001,
      HCD_DB_EVICT = 3'b010,
      HCD_DB_DONE = 3'b100
   } hcd_db_t;

endpackage

// [rtl/hcd_thr_timer.sv]
// Microframe divider and interrupt threshold boundary timer.
`timescale 1ns/100ps
`default_nettype none
module hcd_thr_timer
   import hcd_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic run, // Controller running
   input wire logic [7:0] thresh, // Threshold code in microframes
   output logic boundary // One-cycle pulse at threshold boundary
);

   typedef struct packed {
      logic [11:0] mf_cnt;
      logic [7:0] thr_cnt;
      logic tick;
   } hcd_tmr_t;

   localparam hcd_tmr_t TMR_RST = '{mf_cnt: 12'h000, thr_cnt: 8'h00, tick: 1'b0};

   hcd_tmr_t s_q;
   hcd_tmr_t s_d;

   // Count microframes, pulse when the threshold count is reached
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!run) begin
         s_d.mf_cnt = 12'h000;
         s_d.thr_cnt = 8'h00;
      end else if (s_q.mf_cnt == HCD_MFRAME_LAST) begin
         s_d.mf_cnt = 12'h000;
         if (8'(s_q.thr_cnt + 8'h01) >= thresh) begin
            s_d.thr_cnt = 8'h00;
            s_d.tick = 1'b1;
         end else begin
            s_d.thr_cnt = 8'(s_q.thr_cnt + 8'h01);
         end
      end else begin
         s_d.mf_cnt = 12'(s_q.mf_cnt + 12'h001);
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= TMR_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign boundary = s_q.tick;

endmodule
`default_nettype wire

// [testbench/hcd_cmd_ctrl_assertions.sv]
// Port-level assertions for the host command block.
`timescale 1ns/100ps
`default_nettype none
module hcd_cmd_ctrl_assertions
   import hcd_pkg::*;
#(
   parameter bit LR_IMPL = 1'b1 // Light reset present
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Type
   input wire logic hwrite, // Write
   input wire logic [2:0] hsize, // Size
   input wire logic [31:0] hwdata, // Wdata
   input wire logic hready, // Ready in
   input wire logic [31:0] hrdata, // Rdata
   input wire logic hreadyout, // Ready out
   input wire logic hresp, // Response
   input wire logic irq, // Interrupt
   input wire logic halted // Halted
);
   logic ap_q;
   logic wr_q;
   logic [11:0] ofs_q;
   logic rd_cmd;
   logic rd_sts;
   logic wr_cmd;
   // Data phase tracking
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ap_q <= 1'b0;
         wr_q <= 1'b0;
         ofs_q <= 12'h000;
      end else begin
         ap_q <= hsel & hready & htrans[1];
         wr_q <= hwrite;
         ofs_q <= haddr[11:0];
      end
   end
   // Data phase decodes
   assign rd_cmd = ap_q & ~wr_q & (ofs_q == HCD_CMD_OFS);
   assign rd_sts = ap_q & ~wr_q & (ofs_q == HCD_STS_OFS);
   assign wr_cmd = ap_q & wr_q & (ofs_q == HCD_CMD_OFS);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ready_high_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("hresp not okay");
   idle_rdata_a: assert property (!(ap_q && !wr_q) |-> hrdata == 32'h0)
      else $error("hrdata outside data phase");
   cmd_rsvd_a: assert property (rd_cmd |-> hrdata[15:8] == 8'h00)
      else $error("reserved bits set");
   thr_code_a: assert property (rd_cmd |-> $onehot(hrdata[22:16]) && !hrdata[23])
      else $error("bad threshold code");
   halt_sts_a: assert property (rd_sts |-> hrdata[12] == halted)
      else $error("halt bit mismatch");
   lrst_clear_a: assert property (LR_IMPL && wr_cmd && hwdata[7] |=> halted && !irq)
      else $error("light reset left state");
   lr_absent_a: assert property (rd_cmd && !LR_IMPL |-> !hrdata[7])
      else $error("light reset bit set");
endmodule
bind hcd_cmd_ctrl hcd_cmd_ctrl_assertions #(.LR_IMPL(LR_IMPL)) u_chk (.sys_clk(sys_clk),
   .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .halted(halted));
`default_nettype wire

// [testbench/hcd_cmd_ctrl_tb_top.sv]
// Self-checking bench for the host command block.
`timescale 1ns/100ps
`default_nettype none
module hcd_cmd_ctrl_tb_top;
   import hcd_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [31:0] hrdata_nl;
   logic [31:0] rd_nl;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic halted;
   int num_errors = 0;
   int checks = 0;
   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;
   hcd_cmd_ctrl #(.LR_IMPL(1'b1)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .irq(irq), .halted(halted));
   // Twin without the light reset option, fed the same bus
   hcd_cmd_ctrl #(.LR_IMPL(1'b0)) u_dut_nolr (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata_nl), .hreadyout(), .hresp(), .irq(), .halted());
   // Single word bus transfer
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      rd_nl = hrdata_nl;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string m);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp, m);
   endtask
   task automatic t_reset();
      rchk(HCD_CMD_OFS, 32'h0008_0000, "cmd rst");
      rchk(HCD_STS_OFS, 32'h0000_1000, "sts rst");
      rchk(HCD_IEN_OFS, 32'h0, "ien rst");
      xfer(1'b1, 12'h00c, 32'hffff_ffff);
      rchk(12'h00c, 32'h0, "unmapped");
      xfer(1'b1, HCD_CMD_OFS, 32'h0008_ff00);
      rchk(HCD_CMD_OFS, 32'h0008_0000, "rsvd");
      $display("reset test done");
   endtask
   task automatic t_thr();
      logic [7:0] c;
      for (int i = 0; i < 7; i++) begin
         c = 8'h01 << i;
         xfer(1'b1, HCD_CMD_OFS, {8'h0, c, 16'h0});
         rchk(HCD_CMD_OFS, {8'h0, c, 16'h0}, "thr");
      end
      xfer(1'b1, HCD_CMD_OFS, 32'h0003_0000);
      rchk(HCD_CMD_OFS, 32'h0040_0000, "bad thr");
      $display("threshold test done");
   endtask
   task automatic t_door();
      xfer(1'b1, HCD_IEN_OFS, 32'h20);
      xfer(1'b1, HCD_CMD_OFS, 32'h0008_0020);
      repeat (6) @(posedge sys_clk);
      rchk(HCD_STS_OFS, 32'h1000, "zero ring");
      xfer(1'b1, HCD_CMD_OFS, 32'h0008_0060);
      rchk(HCD_CMD_OFS, 32'h0008_0060, "ringing");
      repeat (8) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h1, "irq");
      rchk(HCD_CMD_OFS, 32'h0008_0020, "db clr");
      rchk(HCD_STS_OFS, 32'h1020, "flag");
      rchk(HCD_STS_OFS, 32'h1000, "flag clr");
      chk({31'h0, irq}, 32'h0, "irq drop");
      $display("doorbell test done");
   endtask
   task automatic t_run();
      int n;
      xfer(1'b1, HCD_CMD_OFS, 32'h0001_0021);
      @(posedge sys_clk);
      chk({31'h0, halted}, 32'h0, "run");
      xfer(1'b1, HCD_CMD_OFS, 32'h0001_0061);
      n = 0;
      while (irq !== 1'b1 && n < 2600) begin
         @(posedge sys_clk);
         n++;
      end
      chk({31'h0, irq}, 32'h1, "irq late");
      chk({31'h0, n > 2000}, 32'h1, "irq early");
      rchk(HCD_STS_OFS, 32'h0020, "flag run");
      xfer(1'b1, HCD_CMD_OFS, 32'h0001_0000);
      @(posedge sys_clk);
      chk({31'h0, halted}, 32'h1, "stop");
      $display("run test done");
   endtask
   task automatic t_lrst();
      xfer(1'b1, HCD_IEN_OFS, 32'h20);
      xfer(1'b1, HCD_CMD_OFS, 32'h0000_0080);
      rchk(HCD_CMD_OFS, 32'h0008_0080, "lr busy");
      chk(rd_nl, 32'h0001_0000, "lr absent");
      xfer(1'b1, HCD_IEN_OFS, 32'h20);
      repeat (16) @(posedge sys_clk);
      rchk(HCD_CMD_OFS, 32'h0008_0000, "lr done");
      rchk(HCD_IEN_OFS, 32'h0, "lr ien");
      $display("light reset test done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_thr();
      t_door();
      t_run();
      t_lrst();
      end_sim();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
